// [design/event_break_trace.sv]
// event break selection and trace capture controller with apb registers
`timescale 1ns/1ps
`include "event_break_trace_defs.svh"

module event_break_trace
#(
   parameter int DEPTH = 64
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   // cpu state and target reset pin
   input  wire logic        run_i,
   input  wire logic        tgt_reset_i,
   // cpu bus data accesses
   input  wire logic        acc_valid_i,
   input  wire logic        acc_write_i,
   input  wire logic [15:0] acc_addr_i,
   input  wire logic [7:0]  acc_data_i,
   input  wire logic        acc_dtc_i,
   // taken branches
   input  wire logic        br_valid_i,
   input  wire logic [15:0] br_src_i,
   input  wire logic [15:0] br_dst_i,
   // break request and trace state
   output logic             break_o,
   output logic             tracing_o
);

   localparam int IDX_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH) + 1;

   logic [`CTRL_WIDTH-1:0] ctrl_q;
   logic [`COND_WIDTH-1:0] eva_q;
   logic [`COND_WIDTH-1:0] evb_q;
   logic [IDX_W-1:0]       tridx_q;
   logic [31:0]            prdata_q;
   logic                   pslverr_q;
   logic [31:0]            trace_mem [DEPTH];
   logic [CNT_W-1:0]       count_q;
   logic                   tracing_q;
   logic                   run_q;
   logic                   rst_meta_q;
   logic                   rst_sync_q;
   logic                   break_q;
   logic                   full_q;

   logic                   run_rise;
   logic                   run_fall;
   logic                   full;
   logic                   full_rise;
   logic                   match_a;
   logic                   match_b;
   logic                   brk_hit;
   logic                   start_hit_ev;
   logic                   stop_hit_ev;
   logic                   start_hit;
   logic                   stop_hit;
   logic                   rec_cand;
   logic                   rec_we;
   logic [31:0]            rec_word;
   logic                   addr_ok;
   logic                   wr_en;
   logic                   setup;
   logic [31:0]            rd_word;

   event_break_trace_pkg::combo_t brk_sel;
   event_break_trace_pkg::combo_t start_sel;
   event_break_trace_pkg::combo_t stop_sel;
   logic [2:0]                    stop_code;

   event_pair_if evp ();

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   // zero wait state; unmapped offsets answer with an error
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_q;
   assign pslverr_o = pslverr_q;
   assign setup     = psel_i & ~penable_i;
   assign wr_en     = psel_i & penable_i & pwrite_i & addr_ok;

   // offset decode
   always_comb
   begin
      addr_ok = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (paddr_i)
         `OFF_CTRL:       rd_word = {20'h00000, ctrl_q};
         `OFF_STATUS:     rd_word = {16'h0000, 8'(count_q), 6'h00, full, tracing_q};
         `OFF_EVA_COND:   rd_word = {13'h0000, eva_q};
         `OFF_EVB_COND:   rd_word = {13'h0000, evb_q};
         `OFF_TRACE_IDX:  rd_word = 32'(tridx_q);
         `OFF_TRACE_DATA: rd_word = trace_mem[tridx_q];
         default:         addr_ok = 1'b0;
      endcase
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (setup)
      begin
         prdata_q  <= pwrite_i ? 32'h0000_0000 : rd_word;
         pslverr_q <= ~addr_ok;
      end
   end

   // control and trace index registers
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q  <= `CTRL_RESET;
         tridx_q <= '0;
      end
      else if (wr_en && paddr_i == `OFF_CTRL)
         ctrl_q <= pwdata_i[`CTRL_WIDTH-1:0];
      else if (wr_en && paddr_i == `OFF_TRACE_IDX)
         tridx_q <= pwdata_i[IDX_W-1:0];
   end

   // one condition per channel; a write replaces the previous one
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         eva_q <= `COND_RESET;
         evb_q <= `COND_RESET;
      end
      else if (wr_en && paddr_i == `OFF_EVA_COND)
         eva_q <= pwdata_i[`COND_WIDTH-1:0];
      else if (wr_en && paddr_i == `OFF_EVB_COND)
         evb_q <= pwdata_i[`COND_WIDTH-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // selections

   // illegal codes fall back to no combination
   always_comb
   begin
      brk_sel   = event_break_trace_pkg::COMBO_NONE;
      start_sel = event_break_trace_pkg::COMBO_NONE;
      stop_sel  = event_break_trace_pkg::COMBO_NONE;
      stop_code = ctrl_q[`CTRL_STOP_MSB:`CTRL_STOP_LSB];
      if (ctrl_q[`CTRL_BRK_MSB:`CTRL_BRK_LSB] < 3'h5)
         brk_sel = event_break_trace_pkg::combo_t'(ctrl_q[`CTRL_BRK_MSB:`CTRL_BRK_LSB]);
      if (ctrl_q[`CTRL_START_MSB:`CTRL_START_LSB] < 3'h5)
         start_sel = event_break_trace_pkg::combo_t'(ctrl_q[`CTRL_START_MSB:`CTRL_START_LSB]);
      if (stop_code < `STOP_SEL_FULL)
         stop_sel = event_break_trace_pkg::combo_t'(stop_code);
   end

   ////////////////////////////////////////////////////////////////////////////
   // event channels

   // channel compare on address and direction; bus fields passed in so callers follow them
   function automatic logic cond_match(input logic [`COND_WIDTH-1:0] c,
                                       input logic [15:0]            addr,
                                       input logic                   wr);
      logic dir_ok;
      dir_ok = (c[`COND_DIR_MSB:`COND_DIR_LSB] == `DIR_ANY)
             || (c[`COND_DIR_MSB:`COND_DIR_LSB] == `DIR_READ && !wr)
             || (c[`COND_DIR_MSB:`COND_DIR_LSB] == `DIR_WRITE && wr);
      return c[`COND_EN] && dir_ok && addr == c[`COND_ADDR_MSB:0];
   endfunction

   // transfer controller accesses never match
   assign match_a = acc_valid_i & ~acc_dtc_i
                  & cond_match(eva_q, acc_addr_i, acc_write_i);
   assign match_b = acc_valid_i & ~acc_dtc_i
                  & cond_match(evb_q, acc_addr_i, acc_write_i);

   // program start edge and synchronised target reset clear the latches
   assign run_rise    = run_i & ~run_q;
   assign run_fall    = ~run_i & run_q;
   assign evp.ev_a    = match_a;
   assign evp.ev_b    = match_b;
   assign evp.restart = run_rise | rst_sync_q;

   // break, start and stop combination units
   event_combiner u_brk
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ev    (evp),
      .sel_i (brk_sel),
      .hit_o (brk_hit)
   );

   event_combiner u_start
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ev    (evp),
      .sel_i (start_sel),
      .hit_o (start_hit_ev)
   );

   event_combiner u_stop
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ev    (evp),
      .sel_i (stop_sel),
      .hit_o (stop_hit_ev)
   );

   ////////////////////////////////////////////////////////////////////////////
   // run edge and target reset synchroniser

   // previous run level
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         run_q <= 1'b0;
      else
         run_q <= run_i;
   end

   // two stages for the target reset pin
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= tgt_reset_i;
         rst_sync_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trace start and stop

   assign full      = (count_q == CNT_W'(DEPTH));
   assign full_rise = full & ~full_q;

   // go start uses the run edge, otherwise the start combination
   assign start_hit = (start_sel == event_break_trace_pkg::COMBO_NONE) ? run_rise
                    : start_hit_ev;

   // stop selection
   always_comb
   begin
      if (stop_code == `STOP_SEL_FULL)
         stop_hit = full;
      else if (stop_sel == event_break_trace_pkg::COMBO_NONE)
         stop_hit = run_fall;
      else
         stop_hit = stop_hit_ev;
   end

   // start wins over a simultaneous stop
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         tracing_q <= 1'b0;
      else if (rst_sync_q)
         tracing_q <= 1'b0;
      else if (start_hit)
         tracing_q <= 1'b1;
      else if (stop_hit)
         tracing_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // trace recording

   // candidate per trace type and pick up filter
   always_comb
   begin
      if (ctrl_q[`CTRL_TYPE_DATA])
      begin
         rec_cand = ctrl_q[`CTRL_PICK_AB] ? (match_a | match_b) : match_a;
         rec_word = {acc_write_i, 7'h00, acc_data_i, acc_addr_i};
      end
      else
      begin
         rec_cand = br_valid_i;
         rec_word = {br_src_i, br_dst_i};
      end
   end

   // tracing_q is still low in the start cycle, so that access is dropped
   assign rec_we = tracing_q & run_i & rec_cand & ~full & ~rst_sync_q;

   // record store
   always_ff @(posedge clk_i)
   begin
      if (rec_we)
         trace_mem[count_q[IDX_W-1:0]] <= rec_word;
   end

   // record count, cleared at program start and target reset
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         count_q <= '0;
      else if (rst_sync_q || run_rise)
         count_q <= '0;
      else if (rec_we)
         count_q <= count_q + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // break request

   // full edge detector
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         full_q <= 1'b0;
      else
         full_q <= full;
   end

   // event break and trace full break act independently
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         break_q <= 1'b0;
      else
         break_q <= run_i & (brk_hit | (ctrl_q[`CTRL_FULL_BRK] & full_rise));
   end

   assign break_o   = break_q;
   assign tracing_o = tracing_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_tgt_reset_seen;
      tgt_reset_i ##2 rst_sync_q;
   endsequence

   property p_tgt_reset_clears;
      @(posedge clk_i) disable iff (rst_i)
      s_tgt_reset_seen |=> (count_q == '0 && !tracing_q);
   endproperty
   a_tgt_reset_clears: assert property (p_tgt_reset_clears)
      else $error("target reset left trace records");

   property p_none_no_break;
      @(posedge clk_i) disable iff (rst_i)
      (brk_sel == event_break_trace_pkg::COMBO_NONE && !ctrl_q[`CTRL_FULL_BRK]) |=> !break_o;
   endproperty
   a_none_no_break: assert property (p_none_no_break)
      else $error("break raised with no break selection");

   property p_a_breaks;
      @(posedge clk_i) disable iff (rst_i)
      (brk_sel == event_break_trace_pkg::COMBO_A && match_a && run_i) |=> break_o;
   endproperty
   a_a_breaks: assert property (p_a_breaks)
      else $error("event a match did not break");

   property p_either_breaks;
      @(posedge clk_i) disable iff (rst_i)
      (brk_sel == event_break_trace_pkg::COMBO_A_OR_B && (match_a || match_b) && run_i)
         |=> break_o;
   endproperty
   a_either_breaks: assert property (p_either_breaks)
      else $error("a or b match did not break");

   property p_full_break;
      @(posedge clk_i) disable iff (rst_i)
      (ctrl_q[`CTRL_FULL_BRK] && full && !full_q && run_i) |=> break_o;
   endproperty
   a_full_break: assert property (p_full_break)
      else $error("trace full did not break");

   property p_start_wins;
      @(posedge clk_i) disable iff (rst_i)
      (start_hit && stop_hit && !rst_sync_q) |=> tracing_q;
   endproperty
   a_start_wins: assert property (p_start_wins)
      else $error("simultaneous stop overrode start");

   property p_full_stops;
      @(posedge clk_i) disable iff (rst_i)
      (stop_code == `STOP_SEL_FULL && full && !start_hit) |=> !tracing_q;
   endproperty
   a_full_stops: assert property (p_full_stops)
      else $error("trace full stop did not end trace");

   property p_dtc_not_recorded;
      @(posedge clk_i) disable iff (rst_i)
      (ctrl_q[`CTRL_TYPE_DATA] && acc_dtc_i && !br_valid_i) |=> $stable(count_q) || count_q == '0;
   endproperty
   a_dtc_not_recorded: assert property (p_dtc_not_recorded)
      else $error("transfer controller access recorded");

   property p_start_not_recorded;
      @(posedge clk_i) disable iff (rst_i)
      (!tracing_q && !run_rise) |=> $stable(count_q) || count_q == '0;
   endproperty
   a_start_not_recorded: assert property (p_start_not_recorded)
      else $error("record stored while trace inactive");

endmodule

// [design/event_break_trace_defs.svh]
// register offsets, field positions, reset values and codes of the break and trace controller
`ifndef EVENT_BREAK_TRACE_DEFS_SVH
`define EVENT_BREAK_TRACE_DEFS_SVH

// register byte offsets
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_EVA_COND    8'h08
`define OFF_EVB_COND    8'h0c
`define OFF_TRACE_IDX   8'h10
`define OFF_TRACE_DATA  8'h14

// control register fields
`define CTRL_BRK_LSB    0
`define CTRL_BRK_MSB    2
`define CTRL_FULL_BRK   3
`define CTRL_TYPE_DATA  4
`define CTRL_START_LSB  5
`define CTRL_START_MSB  7
`define CTRL_STOP_LSB   8
`define CTRL_STOP_MSB   10
`define CTRL_PICK_AB    11
`define CTRL_WIDTH      12
`define CTRL_RESET      12'h000

// status register fields
`define STAT_TRACING    0
`define STAT_FULL       1
`define STAT_CNT_LSB    8

// event condition register fields
`define COND_ADDR_MSB   15
`define COND_EN         16
`define COND_DIR_LSB    17
`define COND_DIR_MSB    18
`define COND_WIDTH      19
`define COND_RESET      19'h00000

// direction codes and stop selection code for trace full
`define DIR_ANY         2'h0
`define DIR_READ        2'h1
`define DIR_WRITE       2'h2
`define STOP_SEL_FULL   3'h5

`endif

// [design/event_break_trace_pkg.sv]
// types shared by the break and trace controller
package event_break_trace_pkg;

   // combination of the two event channels
   typedef enum logic [2:0]
   {
      COMBO_NONE,
      COMBO_A,
      COMBO_A_OR_B,
      COMBO_A_AND_B,
      COMBO_B_THEN_A
   } combo_t;

endpackage

// [design/event_combiner.sv]
// combination of event A and event B into one hit, with occurrence latches
`timescale 1ns/1ps
module event_combiner
(
   // clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           rst_i,
   // event channels
   event_pair_if.snk                           ev,
   // selection and result
   input  event_break_trace_pkg::combo_t       sel_i,
   output logic                                hit_o
);

   logic a_seen_q;
   logic b_seen_q;
   logic armed_q;

   // hit for the selected combination
   always_comb
   begin
      unique case (sel_i)
         event_break_trace_pkg::COMBO_NONE:     hit_o = 1'b0;
         event_break_trace_pkg::COMBO_A:        hit_o = ev.ev_a;
         event_break_trace_pkg::COMBO_A_OR_B:   hit_o = ev.ev_a | ev.ev_b;
         event_break_trace_pkg::COMBO_A_AND_B:  hit_o = (a_seen_q | ev.ev_a)
                                                      & (b_seen_q | ev.ev_b);
         event_break_trace_pkg::COMBO_B_THEN_A: hit_o = ev.ev_a & armed_q;
         default:                               hit_o = 1'b0;
      endcase
   end

   // per-event occurrence latches, consumed on a hit; a match in the restart cycle still counts
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         a_seen_q <= 1'b0;
         b_seen_q <= 1'b0;
      end
      else if (ev.restart || hit_o)
      begin
         a_seen_q <= ev.restart & ~hit_o & ev.ev_a;
         b_seen_q <= ev.restart & ~hit_o & ev.ev_b;
      end
      else
      begin
         a_seen_q <= a_seen_q | ev.ev_a;
         b_seen_q <= b_seen_q | ev.ev_b;
      end
   end

   // armed by B, cleared at program start, consumed by the firing A
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         armed_q <= 1'b0;
      else if (ev.restart)
         armed_q <= ev.ev_b;
      else
         armed_q <= ev.ev_b | (armed_q & ~hit_o);
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_seq_needs_arm;
      @(posedge clk_i) disable iff (rst_i)
      (sel_i == event_break_trace_pkg::COMBO_B_THEN_A && !armed_q) |-> !hit_o;
   endproperty
   a_seq_needs_arm: assert property (p_seq_needs_arm)
      else $error("b then a fired without a prior b");

   property p_arm_by_b;
      @(posedge clk_i) disable iff (rst_i)
      ev.ev_b |=> armed_q;
   endproperty
   a_arm_by_b: assert property (p_arm_by_b)
      else $error("event b did not arm the sequence");

   property p_both_seen_fires;
      @(posedge clk_i) disable iff (rst_i)
      (sel_i == event_break_trace_pkg::COMBO_A_AND_B && a_seen_q && b_seen_q) |-> hit_o;
   endproperty
   a_both_seen_fires: assert property (p_both_seen_fires)
      else $error("both events seen but no hit");

   property p_restart_clears;
      @(posedge clk_i) disable iff (rst_i)
      (ev.restart && !ev.ev_a && !ev.ev_b) |=> (!a_seen_q && !b_seen_q && !armed_q);
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("occurrence latches survived a restart");

endmodule

// [design/event_pair_if.sv]
// event channel matches shared by the combination units
`timescale 1ns/1ps
interface event_pair_if;
   logic ev_a;
   logic ev_b;
   logic restart;

   // driving side in the controller
   modport src
   (
      output ev_a,
      output ev_b,
      output restart
   );

   // combination unit side
   modport snk
   (
      input ev_a,
      input ev_b,
      input restart
   );
endinterface

// [tb/debug_host.sv]
// emulator host model: apb master reaching the controller registers
`timescale 1ns/1ps
module debug_host
(
   // clock
   input  wire logic        clk_i,
   // apb master
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic        pready_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pslverr_i
);
   logic [31:0] rdata_q;
   logic        err_q;

   // bus idle from time zero
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end

   // one transfer: setup, access held until pready, then release
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_i !== 1'b1);
      rdata_q = prdata_i;
      err_q = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the break and trace controller
`timescale 1ns/1ps
`include "event_break_trace_defs.svh"
module tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        run, tgt, av, aw, data_transfer_controller, bv, brk, trc, psel, pen, pwr, rdy, err;
   logic [7:0]  pa, adata;
   logic [15:0] aa, bs, bd;
   logic [31:0] pwd, prd;
   int          errors = 0, n_tests = 0;
   // expected break per selection after A, then B, then A again
   localparam logic [4:0] fa = 5'b00110, fb = 5'b01100, fc = 5'b10110;

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////
   event_break_trace #(.DEPTH(4)) u_event_break_trace
   (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(rdy),
      .prdata_o(prd), .pslverr_o(err), .run_i(run), .tgt_reset_i(tgt),
      .acc_valid_i(av), .acc_write_i(aw), .acc_addr_i(aa), .acc_data_i(adata),
      .acc_dtc_i(data_transfer_controller), .br_valid_i(bv), .br_src_i(bs), .br_dst_i(bd),
      .break_o(brk), .tracing_o(trc)
   );

   debug_host u_debug_host
   (
      .clk_i(clk_i), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
      .paddr_o(pa), .pwdata_o(pwd), .pready_i(rdy), .prdata_i(prd),
      .pslverr_i(err)
   );

   ////////////////////////////////////////////////////////////////////
   // compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      u_debug_host.xfer(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      u_debug_host.xfer(1'b0, a, 32'h0);
      chk(u_debug_host.rdata_q, e);
   endtask

   // one cpu bus access, settled outputs seen one edge later
   task ev(input logic [15:0] a, input logic d);
      @(posedge clk_i);
      av <= 1'b1;
      aw <= a[2];
      aa <= a;
      adata <= a[7:0];
      data_transfer_controller <= d;
      @(posedge clk_i);
      av <= 1'b0;
      #1;
   endtask

   // program stop then start
   task go;
      @(posedge clk_i);
      run <= 1'b0;
      @(posedge clk_i);
      run <= 1'b1;
      @(posedge clk_i);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////
   // reset values, read-only status, replaced condition, unmapped offset
   task t_regs;
      rd(`OFF_CTRL, 32'h0);
      wr(`OFF_STATUS, 32'hffff_ffff);
      rd(`OFF_STATUS, 32'h0);
      wr(`OFF_EVA_COND, 32'h0001_0400);
      wr(`OFF_EVA_COND, 32'h0001_0408);
      rd(`OFF_EVA_COND, 32'h0001_0408);
      rd(8'h18, 32'h0);
      chk(u_debug_host.err_q, 1'b1);
   endtask

   // every break selection against one access sequence
   task t_break;
      wr(`OFF_EVA_COND, 32'h0001_0400);
      wr(`OFF_EVB_COND, 32'h0001_0404);
      for (int s = 0; s < 5; s++)
      begin
         wr(`OFF_CTRL, 32'(s));
         go();
         ev(16'h0400, 1'b1);
         chk(brk, 1'b0);
         ev(16'h0400, 1'b0);
         chk(brk, fa[s]);
         ev(16'h0404, 1'b0);
         chk(brk, fb[s]);
         ev(16'h0400, 1'b0);
         chk(brk, fc[s]);
      end
      // direction filter: read-only, then write-only condition against a write access
      wr(`OFF_CTRL, 32'h1);
      wr(`OFF_EVA_COND, 32'h0003_0404);
      ev(16'h0404, 1'b0);
      chk(brk, 1'b0);
      wr(`OFF_EVA_COND, 32'h0005_0404);
      ev(16'h0404, 1'b0);
      chk(brk, 1'b1);
      wr(`OFF_EVA_COND, 32'h0001_0400);
   endtask

   // branch trace from program start to program stop
   task t_branch;
      wr(`OFF_CTRL, 32'h0);
      go();
      chk(trc, 1'b1);
      @(posedge clk_i);
      bv <= 1'b1;
      bs <= 16'h1234;
      bd <= 16'hedcb;
      @(posedge clk_i);
      bv <= 1'b0;
      run <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(trc, 1'b0);
      rd(`OFF_STATUS, 32'h0000_0100);
      wr(`OFF_TRACE_IDX, 32'h0);
      rd(`OFF_TRACE_DATA, 32'h1234_edcb);
   endtask

   // data trace started by A, filled to depth, then target reset
   task t_data;
      logic seen;
      seen = 1'b0;
      wr(`OFF_CTRL, 32'h0000_0d3a);
      go();
      chk(trc, 1'b0);
      ev(16'h0400, 1'b0);
      chk(trc, 1'b1);
      ev(16'h0404, 1'b0);
      ev(16'h0500, 1'b0);
      ev(16'h0404, 1'b1);
      repeat (3) ev(16'h0400, 1'b0);
      repeat (3)
      begin
         @(posedge clk_i);
         #1;
         seen = seen | brk;
      end
      chk(seen, 1'b1);
      chk(trc, 1'b0);
      rd(`OFF_STATUS, 32'h0000_0402);
      wr(`OFF_TRACE_IDX, 32'h0);
      rd(`OFF_TRACE_DATA, 32'h8004_0404);
      wr(`OFF_TRACE_IDX, 32'h1);
      rd(`OFF_TRACE_DATA, 32'h0000_0400);
      @(posedge clk_i);
      tgt <= 1'b1;
      @(posedge clk_i);
      tgt <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(`OFF_STATUS, 32'h0);
   endtask

   // start and stop on the same access, then stop on B
   task t_ss;
      wr(`OFF_CTRL, 32'h0000_0230);
      go();
      ev(16'h0400, 1'b0);
      chk(trc, 1'b1);
      ev(16'h0404, 1'b0);
      chk(trc, 1'b0);
      rd(`OFF_STATUS, 32'h0);
   endtask

   task results;
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // watchdog well beyond the roughly two hundred cycles needed
   initial
   begin
      #200us;
      errors++;
      results();
   end

   // main sequence
   initial
   begin
      {run, tgt, av, aw, data_transfer_controller, bv} = 6'h00;
      {aa, bs, bd, adata} = 56'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_break();
      t_branch();
      t_data();
      t_ss();
      results();
   end
endmodule
